// ===== cpa_pkg.sv
// Purpose: constants and types for the camera preview accel control
// Assumes: 32-bit APB, byte addresses, one aligned word per register
// Notes: all offsets, control bit positions and the control reset value live here
package cpa_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [31:0] CPA_OFF_CON = 32'h0000_0704; // camera_if_control
	localparam logic [31:0] CPA_OFF_TGT = 32'h0000_0708; // display_target_select
	localparam logic [31:0] CPA_OFF_STS = 32'h0000_070C; // live status

	localparam logic [15:0] CPA_CON_RST = 16'h0000; // control reset value
	localparam logic [15:0] CPA_CON_WMASK = 16'hFFCF; // bits 5:4 reserved
	localparam int CPA_TGT_W = 2; // display target field width

	// ------------------------------------------------------------
	// control bit positions
	// ------------------------------------------------------------
	localparam int CPA_B_PCLK_SEL = 15; // pixel_clock_source_sel
	localparam int CPA_B_DISP_EN = 14; // display_request_en
	localparam int CPA_B_DREQ_SEL = 13; // dma_request_source_sel
	localparam int CPA_B_DMA_EN = 12; // dma_request_en
	localparam int CPA_B_PCLK_INV = 11; // pixel_clock_invert
	localparam int CPA_B_SLEW = 10; // display_port_slew
	localparam int CPA_B_DRV_A = 9; // display_port_drive_a
	localparam int CPA_B_DRV_B = 8; // display_port_drive_b
	localparam int CPA_B_DRV_C = 7; // display_port_drive_c
	localparam int CPA_B_IRQ_INV = 6; // line30_irq_invert
	localparam int CPA_B_CLK_HI = 3; // clock_out_upper_drive
	localparam int CPA_B_CLK_LO = 2; // clock_out_lower_drive
	localparam int CPA_B_RAD_A = 1; // radio_pin3_drive_a
	localparam int CPA_B_RAD_B = 0; // radio_pin3_drive_b

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	// sensor side pin levels
	typedef struct packed {
		logic chip_select3_pin; // line sync or pixel clock
		logic display_select1_pin; // pixel clock, or irq line 30 level
		logic ext_irq2_pin; // alternate line sync
	} cpa_pins_type;

	// pad settings driven to the pad ring
	typedef struct packed {
		logic clock_out_upper_drive; // 0: 2mA, 1: 14mA
		logic clock_out_lower_drive; // 0: 2mA, 1: 14mA
		logic display_port_slew; // slew control
		logic [2:0] display_port_drive; // a, b, c
		logic [1:0] radio_pin3_drive; // a, b
	} cpa_pad_type;

endpackage : cpa_pkg

// ===== cpa_ctrl.sv
// Purpose: control logic for camera preview and capture acceleration
// Assumes: pins synchronous to pclk but resampled; APB slave, 0 waits
// Notes: requests are one-cycle pulses on qualifying pixel clock edges
`timescale 1ns/1ps

// How it works
// - bit 15 picks pixel clock pin when bit 13 set
// - bit 11 inverts selected pixel clock
// - bit 12 gates DMA requests
// - bit 13 picks DMA line sync source
// - bit 14 enables display request, sensor bus
// - bit 6 inverts display select as irq
// - bits 3,2 pick clock pad drive
// - display pad, radio pad bits, reset 0
// - bit 12 paces DMA by sync, clock
// - target register names receiving display
module cpa_ctrl (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// sensor side pins
	input wire cpa_pkg::cpa_pins_type pins,
	// requests and controls
	output logic dma_req,
	output logic display_req,
	output logic sensor_bus_en,
	output logic irq_line30,
	output logic [cpa_pkg::CPA_TGT_W-1:0] display_target_select,
	output cpa_pkg::cpa_pad_type pad
);
	import cpa_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	// all state in one record
	typedef struct packed {
		logic [15:0] ctrl; // camera_if_control
		logic [CPA_TGT_W-1:0] tgt; // display target
		logic [2:0] s1; // sync stage one
		logic [2:0] s2; // sync stage two
		logic pclk_prev; // last selected pixel clock
		logic [15:0] evt_cnt; // qualifying events seen
		logic [31:0] rdata; // read data
		logic rdy; // apb ready
		logic err; // apb error
		logic dma; // dma request pulse
		logic disp; // display request pulse
		logic sens; // sensor bus enable
		logic irq; // line 30 interrupt level
		cpa_pad_type pad; // pad settings
	} cpa_state_type;

	cpa_state_type st_q; // registered state
	cpa_state_type st_d; // next state

	logic pclk_sel; // selected, polarity-corrected clock
	logic hs_sel; // selected line sync
	logic evt; // one qualifying event
	logic wr_acc; // write accepted this edge

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// word address match
	function automatic logic cpa_hit(input logic [31:0] a,
		input logic [31:0] off);
		cpa_hit = (a[31:2] == off[31:2]);
	endfunction : cpa_hit

	// ------------------------------------------------------------
	// source selection
	// ------------------------------------------------------------
	// picks line sync and pixel clock from synced pins
	always_comb begin
		logic cs3; // synced chip select 3
		logic ds1; // synced display select 1
		logic ei2; // synced ext irq 2
		logic raw; // pixel clock before polarity
		raw = 1'b0; // defined before any branch
		cs3 = st_q.s2[2];
		ds1 = st_q.s2[1];
		ei2 = st_q.s2[0];
		if (st_q.ctrl[CPA_B_DREQ_SEL]) begin
			hs_sel = ei2;
			// clock pin by select bit
			raw = st_q.ctrl[CPA_B_PCLK_SEL] ? ds1 : cs3;
		end else begin
			// fixed pairing: sync on cs3, clock on ds1
			hs_sel = cs3;
			raw = ds1;
		end
		pclk_sel = raw ^ st_q.ctrl[CPA_B_PCLK_INV];
		evt = pclk_sel & ~st_q.pclk_prev & hs_sel;
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	// register file, apb answer and request pulses
	always_comb begin
		st_d = st_q;
		wr_acc = psel & penable & pwrite & st_q.rdy & ~st_q.err;
		// synchroniser: stage one feeds stage two only
		st_d.s1 = pins;
		st_d.s2 = st_q.s1;
		st_d.pclk_prev = pclk_sel;
		// apb setup phase: decode and prepare answer
		st_d.rdy = psel & ~penable;
		st_d.err = 1'b0;
		if (psel & ~penable) begin
			st_d.rdata = 32'h0000_0000;
			if (cpa_hit(paddr, CPA_OFF_CON)) begin
				st_d.rdata[15:0] = st_q.ctrl;
			end else if (cpa_hit(paddr, CPA_OFF_TGT)) begin
				st_d.rdata[CPA_TGT_W-1:0] = st_q.tgt;
			end else if (cpa_hit(paddr, CPA_OFF_STS)) begin
				st_d.rdata[18:16] = st_q.s2;
				st_d.rdata[15:0] = st_q.evt_cnt;
			end else begin
				// unmapped: error answer
				st_d.err = 1'b1;
			end
		end
		// apb access phase: write takes effect
		if (wr_acc) begin
			if (cpa_hit(paddr, CPA_OFF_CON)) begin
				st_d.ctrl = pwdata[15:0] & CPA_CON_WMASK;
			end else if (cpa_hit(paddr, CPA_OFF_TGT)) begin
				st_d.tgt = pwdata[CPA_TGT_W-1:0];
			end else if (cpa_hit(paddr, CPA_OFF_STS)) begin
				// status is read-only; write ignored
				st_d.evt_cnt = st_q.evt_cnt;
			end
		end
		// request pulses
		st_d.dma = evt & st_q.ctrl[CPA_B_DMA_EN];
		st_d.disp = evt & st_q.ctrl[CPA_B_DISP_EN];
		if (evt) begin
			st_d.evt_cnt = st_q.evt_cnt + 16'h0001;
		end
		// sensor drives shared bus when display path on
		st_d.sens = st_q.ctrl[CPA_B_DISP_EN];
		// display select used as irq line 30
		st_d.irq = st_q.s2[1] ^ st_q.ctrl[CPA_B_IRQ_INV];
		// pad settings
		st_d.pad.clock_out_upper_drive = st_q.ctrl[CPA_B_CLK_HI];
		st_d.pad.clock_out_lower_drive = st_q.ctrl[CPA_B_CLK_LO];
		st_d.pad.display_port_slew = st_q.ctrl[CPA_B_SLEW];
		st_d.pad.display_port_drive = {st_q.ctrl[CPA_B_DRV_A],
			st_q.ctrl[CPA_B_DRV_B], st_q.ctrl[CPA_B_DRV_C]};
		st_d.pad.radio_pin3_drive = {st_q.ctrl[CPA_B_RAD_A],
			st_q.ctrl[CPA_B_RAD_B]};
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// single flop bank, constant reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
			st_q.ctrl <= CPA_CON_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// all straight from flops
	assign prdata = st_q.rdata;
	assign pready = st_q.rdy;
	assign pslverr = st_q.err;
	assign dma_req = st_q.dma;
	assign display_req = st_q.disp;
	assign sensor_bus_en = st_q.sens;
	assign irq_line30 = st_q.irq;
	assign display_target_select = st_q.tgt;
	assign pad = st_q.pad;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// request needs the gate set one cycle before
	AST_DMA_GATE: assert property (
		dma_req |-> $past(st_q.ctrl[CPA_B_DMA_EN]))
		else $error("dma request while gate off");

	// qualifying edge with gate on gives a request next cycle
	AST_DMA_FIRE: assert property (
		evt && st_q.ctrl[CPA_B_DMA_EN] |=> dma_req)
		else $error("missed dma request");

	// one pulse per event, never two in a row
	AST_ONE_PULSE: assert property (
		dma_req |=> !dma_req)
		else $error("dma request longer than one cycle");

	// line sync must have been high at the event
	AST_SYNC_HIGH: assert property (
		display_req |-> $past(hs_sel))
		else $error("display request without line sync");

	// sensor enable follows a control write within two cycles
	AST_SENSOR_EN: assert property (
		wr_acc && cpa_hit(paddr, CPA_OFF_CON)
		|-> ##2 sensor_bus_en == $past(pwdata[CPA_B_DISP_EN], 2))
		else $error("sensor enable did not follow write");

	// irq line tracks synced pin and invert bit
	AST_IRQ30: assert property (
		$stable(st_q.ctrl) && $stable(st_q.s2)
		|=> irq_line30 == $past(st_q.s2[1] ^ st_q.ctrl[CPA_B_IRQ_INV]))
		else $error("irq line 30 level wrong");

	// clock pad drive tracks control bits
	AST_PAD_CLK: assert property (
		##1 pad.clock_out_lower_drive == $past(st_q.ctrl[CPA_B_CLK_LO])
		&& pad.clock_out_upper_drive == $past(st_q.ctrl[CPA_B_CLK_HI]))
		else $error("clock pad drive mismatch");

	// reserved bits never stored
	AST_RSVD: assert property (
		st_q.ctrl[5:4] == 2'b00)
		else $error("reserved control bits set");

	// target write is visible on the output next cycle
	AST_TARGET: assert property (
		wr_acc && cpa_hit(paddr, CPA_OFF_TGT)
		|=> display_target_select == $past(pwdata[CPA_TGT_W-1:0]))
		else $error("display target not updated");

	// unmapped access answers with error in the access cycle
	AST_UNMAPPED: assert property (
		psel && !penable && !cpa_hit(paddr, CPA_OFF_CON)
		&& !cpa_hit(paddr, CPA_OFF_TGT) && !cpa_hit(paddr, CPA_OFF_STS)
		|=> pready && pslverr)
		else $error("unmapped access not refused");

	// fixed pairing: sync on cs3 and clock on ds1 both high at the event
	AST_FIX_PAIR: assert property (
		evt && !st_q.ctrl[CPA_B_DREQ_SEL] && !st_q.ctrl[CPA_B_PCLK_INV]
		|-> st_q.s2[2] && st_q.s2[1])
		else $error("fixed pairing event with wrong pin levels");

	// inverted fixed clock: event happens while ds1 is low
	AST_FIX_INV: assert property (
		evt && !st_q.ctrl[CPA_B_DREQ_SEL] && st_q.ctrl[CPA_B_PCLK_INV]
		|-> st_q.s2[2] && !st_q.s2[1])
		else $error("inverted clock event with wrong pin levels");

	// alternate sync with clock taken from cs3
	AST_ALT_CS3: assert property (
		evt && st_q.ctrl[CPA_B_DREQ_SEL] && !st_q.ctrl[CPA_B_PCLK_SEL]
		&& !st_q.ctrl[CPA_B_PCLK_INV] |-> st_q.s2[0] && st_q.s2[2])
		else $error("alternate source event not on cs3 clock");

	// alternate sync with clock taken from ds1
	AST_ALT_DS1: assert property (
		evt && st_q.ctrl[CPA_B_DREQ_SEL] && st_q.ctrl[CPA_B_PCLK_SEL]
		&& !st_q.ctrl[CPA_B_PCLK_INV] |-> st_q.s2[0] && st_q.s2[1])
		else $error("alternate source event not on ds1 clock");

	// display request needs its gate one cycle before
	AST_DISP_GATE: assert property (
		display_req |-> $past(st_q.ctrl[CPA_B_DISP_EN]))
		else $error("display request while gate off");

	// qualifying event with display gate on fires next cycle
	AST_DISP_FIRE: assert property (
		evt && st_q.ctrl[CPA_B_DISP_EN] |=> display_req)
		else $error("missed display request");

	// display request is a single-cycle pulse
	AST_DISP_PULSE: assert property (
		display_req |=> !display_req)
		else $error("display request longer than one cycle");

	// ready stands for the access cycle only
	AST_READY_ONE: assert property (
		pready |=> !pready)
		else $error("ready held beyond access cycle");

	// error answer only comes with ready
	AST_ERR_READY: assert property (
		pslverr |-> pready)
		else $error("error without ready");

	// control word changes only by an accepted control write
	AST_CTRL_HOLD: assert property (
		!(wr_acc && cpa_hit(paddr, CPA_OFF_CON)) |=> $stable(st_q.ctrl))
		else $error("control word changed without write");

	// target changes only by an accepted target write
	AST_TGT_HOLD: assert property (
		!(wr_acc && cpa_hit(paddr, CPA_OFF_TGT)) |=> $stable(display_target_select))
		else $error("display target changed without write");

	// control read answers with the stored word, upper half zero
	AST_RD_CON: assert property (
		psel && !penable && cpa_hit(paddr, CPA_OFF_CON)
		|=> prdata == {16'h0000, $past(st_q.ctrl)} && !pslverr)
		else $error("control read data wrong");

	// target read answers with the stored target
	AST_RD_TGT: assert property (
		psel && !penable && cpa_hit(paddr, CPA_OFF_TGT)
		|=> prdata == 32'($past(display_target_select)) && !pslverr)
		else $error("target read data wrong");

	// display pad slew and drive follow their control bits
	AST_DISP_DRIVE: assert property (
		##1 pad.display_port_slew == $past(st_q.ctrl[CPA_B_SLEW])
		&& pad.display_port_drive == $past(st_q.ctrl[CPA_B_DRV_A:CPA_B_DRV_C]))
		else $error("display pad drive mismatch");

	// radio pin 3 drive follows its control bits
	AST_RADIO_DRIVE: assert property (
		##1 pad.radio_pin3_drive == $past(st_q.ctrl[CPA_B_RAD_A:CPA_B_RAD_B]))
		else $error("radio pad drive mismatch");

	// main scenarios
	CVR_DMA: cover property (dma_req);
	CVR_DISP: cover property (display_req && sensor_bus_en);
	CVR_ALT_SRC: cover property (dma_req && st_q.ctrl[CPA_B_DREQ_SEL]
		&& st_q.ctrl[CPA_B_PCLK_SEL]);
	CVR_INV: cover property (dma_req && st_q.ctrl[CPA_B_PCLK_INV]);
	CVR_REFUSE: cover property (pready && pslverr);

endmodule : cpa_ctrl

// ===== cpa_sensor_model.sv
// Purpose: image sensor stand-in driving line sync and pixel clock pins
// Assumes: pins are sampled on pclk; each random level is held four cycles
// Notes: all pins rest low outside frames
`timescale 1ns/1ps
module cpa_sensor_model (
	// clock and frame gate
	input wire logic pclk,
	input wire logic frame_en,
	// sensor pins
	output cpa_pkg::cpa_pins_type pins
);
	import cpa_pkg::*;
	integer seed = 42573; // fixed seed
	logic [1:0] hold_q = 2'h0; // hold counter
	initial pins = '0;
	// fresh levels every fourth cycle, paced like a slow pixel clock
	always @(posedge pclk) begin
		hold_q <= hold_q + 2'h1;
		if (!frame_en) begin
			pins <= '0; // pixel clock stands still between frames
		end else if (hold_q == 2'h3) begin
			pins <= 3'($random(seed));
		end
	end
endmodule : cpa_sensor_model

// ===== camera_preview_accel_ctrl_tb_top.sv
// Purpose: self-checking bench for the camera preview accel control
// Assumes: zero-wait APB slave; requests follow synced pins by three edges
// Notes: a reference model counts qualifying pixel clock edges
`timescale 1ns/1ps
module camera_preview_accel_ctrl_tb_top;
	import cpa_pkg::*;
	// ------------------------------------------------------------
	// signals and reference state
	// ------------------------------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready, pslverr, dma_req, display_req, sensor_bus_en, irq_line30;
	logic frame_en = 1'b0; // sensor frame gate
	logic [CPA_TGT_W-1:0] display_target_select;
	cpa_pins_type pins, prev_pins;
	cpa_pad_type pad;
	integer error_cnt = 0, tests_run = 0, seed = 42573;
	integer exp_evt = 0, dma_cnt = 0, disp_cnt = 0, stable_cnt = 0, tot_evt = 0;
	logic [15:0] ref_con = '0; // model of the control word
	logic prev_clk = 1'b0;
	logic [31:0] rd, v;
	logic err;

	always #4 pclk = ~pclk;

	cpa_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .pins, .dma_req, .display_req, .sensor_bus_en, .irq_line30,
		.display_target_select, .pad);
	cpa_sensor_model sensor (.pclk(pclk), .frame_en(frame_en), .pins(pins));

	// ------------------------------------------------------------
	// reference model and shared tasks
	// ------------------------------------------------------------
	function automatic logic sel_clk(input cpa_pins_type p, input logic [15:0] c);
		sel_clk = (c[13] ? (c[15] ? p.display_select1_pin : p.chip_select3_pin)
			: p.display_select1_pin) ^ c[11];
	endfunction : sel_clk

	function automatic logic sel_sync(input cpa_pins_type p, input logic [15:0] c);
		sel_sync = c[13] ? p.ext_irq2_pin : p.chip_select3_pin;
	endfunction : sel_sync

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	// one APB transfer; waits for pready, the watchdog bounds the wait
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic end_of_test;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_of_test

	// event counting on every edge; irq level checked in frames once pins have held for three edges
	always @(posedge pclk) begin
		if (sel_clk(pins, ref_con) && !prev_clk && sel_sync(pins, ref_con)) begin
			exp_evt++;
			tot_evt++;
		end
		prev_clk = sel_clk(pins, ref_con);
		dma_cnt += (dma_req === 1'b1);
		disp_cnt += (display_req === 1'b1);
		stable_cnt = (pins === prev_pins) ? stable_cnt + 1 : 0;
		prev_pins = pins;
		if (frame_en && stable_cnt == 3) begin
			chk(irq_line30, pins.display_select1_pin ^ ref_con[6]);
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(32'(pad), 32'h0);
		apb(1'b0, CPA_OFF_CON, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 32'h0000_0700, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		// random control words, readback and pad outputs
		repeat (6) begin
			v = $random(seed);
			apb(1'b1, CPA_OFF_CON, v);
			ref_con = v[15:0] & CPA_CON_WMASK;
			apb(1'b0, CPA_OFF_CON, 32'h0);
			chk(rd, 32'(ref_con));
			chk(32'(pad), 32'({ref_con[3:2], ref_con[10:7], ref_con[1:0]}));
			chk(32'(sensor_bus_en), 32'(ref_con[14]));
		end
		// display target register
		v = $random(seed);
		apb(1'b1, CPA_OFF_TGT, v);
		apb(1'b0, CPA_OFF_TGT, 32'h0);
		chk(rd, v & 32'h3);
		chk(32'(display_target_select), v & 32'h3);
		// every source, polarity and gate combination with a sensor frame
		// software side: baseband output held off before bit 14
		// no display DMA engine in use on the direct path
		// sensor frame matches display size, RGB output
		// DMA channel and master are set by software; requests counted
		for (int k = 0; k < 32; k++) begin
			v = $random(seed);
			v[15:11] = k[4:0];
			apb(1'b1, CPA_OFF_CON, v);
			ref_con = v[15:0] & CPA_CON_WMASK;
			repeat (4) @(posedge pclk);
			exp_evt = 0;
			dma_cnt = 0;
			disp_cnt = 0;
			frame_en <= 1'b1;
			repeat (160) @(posedge pclk);
			frame_en <= 1'b0;
			repeat (8) @(posedge pclk);
			chk(dma_cnt, ref_con[12] ? exp_evt : 0);
			chk(disp_cnt, ref_con[14] ? exp_evt : 0);
		end
		// status: event count kept, writes ignored without error
		apb(1'b1, CPA_OFF_STS, 32'hFFFF_FFFF);
		chk({31'h0, err}, 32'h0);
		apb(1'b0, CPA_OFF_STS, 32'h0);
		chk(rd, tot_evt & 32'h0000_FFFF);
		// unmapped write refused and dropped
		apb(1'b1, 32'h0000_0710, 32'hFFFF_FFFF);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, CPA_OFF_CON, 32'h0);
		chk(rd, 32'(ref_con));
		end_of_test();
	end

	// watchdog well beyond the expected run length
	initial begin
		#(40000 * 8);
		error_cnt++;
		$display("unexpected at %0t: watchdog expired", $time);
		end_of_test();
	end
endmodule : camera_preview_accel_ctrl_tb_top
